// ### rtl/mwd_decode.sv
// Microword field decode, branch-test multiplexing and microcycle sequencing.
//
// Overview of operation
// - Register-immediate bit 13 makes bits 12:9 the scratch pad address.
// - Bits 16:13 choose immediate, bus-address, destination or source register mode.
// - The branch field enables alteration of the pointer next address.
// - Bit 22 set routes the ALU output into the bus address register.
// - D selector codes 0,1,2,3 pick inputs A,B,C,D.
// - Bits 28:25 drive the B selector byte sections directly.
// - Bits 32:29 go to the B constant generator.
// - ALU field 37:33 may be replaced by an instruction-register function.
// - Status field encodes what loads into the status word and when.
// - Alteration field 44:41 enables stack checks on bus cycles; every bus cycle enables the odd-address check.
// - Bus field 47:45 gives transfer-type signals and begin-bus-cycle.
// - Bits 48, 49, 50 enable bus address, D and B register clocks.
// - Bits 52 and 51 write upper and lower scratch pad bytes.
// - Bit 55 enables instruction register clocking.
// - Clock field gives cycle length code and clock stop.
// - All fields except the pointer are held true in ROM and buffer.
// - Bit 0 two muxes, bit 1 sixteen, bits 2-3 eight, bits 4-5 four inputs.
// - Dispatch tests 34-37 reach every branch bit; 30-33 four, others one or two.
// - Group decode of tests 30-37 enables muxes and flag clocking.
// - Selected codes and expansion codes are ORed onto bits 5:1.
// - Bit 0 has separate high and low test inputs, no expansion code.
// - Complemented pointer is re-inverted; buffer holds true, branched address.
// - Length codes 00/01 short, 10 medium, 11 long; 140, 200, 300 ns.
// - Clock stop halts after the word until an asynchronous or control-register start arrives.
`timescale 1ns/100ps
module mwd_decode (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Microprogram ROM
  output logic [mwd_pkg::PTR_W-1:0] rom_addr,
  input wire logic [mwd_pkg::MW_W-1:0] rom_word,
  // Instruction decode inputs
  input wire logic [2:0] ir_src_reg,
  input wire logic [2:0] ir_dst_reg,
  input wire logic [3:0] busaddr_low,
  input wire logic [4:0] ir_alu_op,
  // Branch codes
  input wire logic [15:0] branch_bit0_low_tests,
  input wire logic [15:0] branch_bit0_high_tests,
  input wire logic [15:0] bc1_in,
  input wire logic [7:0] bc2_in,
  input wire logic [7:0] bc3_in,
  input wire logic [3:0] bc4_in,
  input wire logic [3:0] bc5_in,
  input wire logic [5:1] exp_branch_code,
  // Run control
  input wire logic start_async,
  output logic running,
  output logic cycle_strobe,
  // Data path controls
  output mwd_pkg::mwd_ctl_t ctl
);
  import mwd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Start synchroniser and run state.

  logic start_meta_r;
  logic start_sync_r;
  logic start_seen_r;
  mwd_state_t state_r;
  logic [4:0] cnt_r;
  logic stop_pend_r;
  logic [1:0] ctrl_r;
  logic soft_start;
  logic start_evt;
  logic end_w;
  logic load_w;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_meta_r <= 1'b0;
      start_sync_r <= 1'b0;
      start_seen_r <= 1'b0;
    end
    else
    begin
      start_meta_r <= start_async;
      start_sync_r <= start_meta_r;
      start_seen_r <= start_sync_r;
    end
  end

  assign start_evt = (start_sync_r & ~start_seen_r) | soft_start;
  assign end_w = (state_r == MWD_RUN) && (cnt_r == 5'h00);
  assign load_w = end_w && !stop_pend_r;

  function automatic logic [4:0] len_of(input logic [1:0] code);
    unique case (code)
      2'b00, 2'b01: len_of = CYC_SHORT;
      2'b10: len_of = CYC_MED;
      2'b11: len_of = CYC_LONG;
    endcase
  endfunction : len_of

  // A start arriving in the cycle that halts the machine keeps it running.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= MWD_IDLE;
    else if (start_evt)
      state_r <= MWD_RUN;
    else if (end_w && stop_pend_r)
      state_r <= MWD_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 5'h00;
    else if (state_r == MWD_IDLE)
      cnt_r <= 5'h00;
    else if (load_w)
      cnt_r <= len_of(rom_word[CYCLE_LENGTH_CODE_LSB +: 2]) - 5'h01;
    else if (cnt_r != 5'h00)
      cnt_r <= cnt_r - 5'h01;
  end

  // The stop is latched with the word so a mid-cycle halt write cannot clip it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_pend_r <= 1'b0;
    else if (load_w)
      stop_pend_r <= rom_word[CLOCK_STOP_BIT_BIT] | ctrl_r[CTRL_HALT_BIT];
    else if (start_evt)
      stop_pend_r <= 1'b0;
  end

  assign running = (state_r == MWD_RUN);

  //////////////////////////////////////////////////////////////////////////////
  // Word buffer and next-address formation.

  logic [MW_W-1:0] uword_r;
  logic [PTR_W-1:0] upp_r;
  logic [PTR_W-1:0] prev_r;
  logic [PTR_W-1:0] naddr;
  logic [BTEST_W-1:0] btest;
  logic grp20;
  logic grp30;
  logic grp34;
  logic [5:0] bmod;
  logic b0_hi;
  logic b0_lo;

  assign btest = rom_word[BTEST_LSB +: BTEST_W];
  assign grp20 = btest[4];
  assign grp30 = btest[4] & btest[3];
  assign grp34 = grp30 & btest[2];

  // Bit 0 needs two muxes: the low tests and the high tests are gated by opposite values of test bit 4.
  mwd_bmux #(.N(16)) u_mux0_lo (
    .sel(btest[3:0]),
    .en(!grp20 && (btest != 5'h00)),
    .din(branch_bit0_low_tests),
    .dout(b0_lo)
  );
  mwd_bmux #(.N(16)) u_mux0_hi (
    .sel(btest[3:0]),
    .en(grp20),
    .din(branch_bit0_high_tests),
    .dout(b0_hi)
  );
  mwd_bmux #(.N(16)) u_mux1 (
    .sel(btest[3:0]),
    .en(grp20),
    .din(bc1_in),
    .dout(bmod[1])
  );
  mwd_bmux #(.N(8)) u_mux2 (
    .sel(btest[2:0]),
    .en(grp30),
    .din(bc2_in),
    .dout(bmod[2])
  );
  mwd_bmux #(.N(8)) u_mux3 (
    .sel(btest[2:0]),
    .en(grp30),
    .din(bc3_in),
    .dout(bmod[3])
  );
  mwd_bmux #(.N(4)) u_mux4 (
    .sel(btest[1:0]),
    .en(grp34),
    .din(bc4_in),
    .dout(bmod[4])
  );
  mwd_bmux #(.N(4)) u_mux5 (
    .sel(btest[1:0]),
    .en(grp34),
    .din(bc5_in),
    .dout(bmod[5])
  );

  assign bmod[0] = b0_lo | b0_hi;

  // The branch is applied as the word is loaded, so the ROM is addressed with no lag.
  always_comb
  begin
    naddr = ~rom_word[PTR_LSB +: PTR_W];
    if (btest != 5'h00)
      naddr = naddr | {3'h0, bmod[5:1] | exp_branch_code, bmod[0]};
  end

  // Only the pointer is re-inverted and branched; every other field is taken as is.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      uword_r <= '0;
    else if (load_w)
      uword_r <= {rom_word[MW_W-1:PTR_W], naddr};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upp_r <= '0;
      prev_r <= '0;
      cycle_strobe <= 1'b0;
    end
    else
    begin
      cycle_strobe <= load_w;
      if (load_w)
      begin
        prev_r <= upp_r;
        upp_r <= naddr;
      end
    end
  end

  assign rom_addr = upp_r;

  //////////////////////////////////////////////////////////////////////////////
  // Field decode into the data-path control register.

  mwd_ctl_t ctl_nxt;
  logic [2:0] rsel;
  logic [2:0] bus_code;
  logic [3:0] dad;

  always_comb
  begin
    rsel = rom_word[RSEL_LSB +: 3];
    bus_code = rom_word[BUS_LSB +: 3];
    dad = rom_word[DAD_LSB +: 4];
    ctl_nxt = CTL_RESET;
    // Immediate wins over the other three modes.
    if (rom_word[RIMM_BIT])
    begin
      ctl_nxt.sp_mode = MWD_SP_IMM;
      ctl_nxt.sp_addr = rom_word[RIF_LSB +: 4];
    end
    else if (rsel[0])
    begin
      ctl_nxt.sp_mode = MWD_SP_BUSADDR;
      ctl_nxt.sp_addr = busaddr_low;
    end
    else if (rsel[1])
    begin
      ctl_nxt.sp_mode = MWD_SP_DEST;
      ctl_nxt.sp_addr = {1'b0, ir_dst_reg};
    end
    else
    begin
      ctl_nxt.sp_mode = MWD_SP_SRC;
      ctl_nxt.sp_addr = {1'b0, ir_src_reg};
    end
    ctl_nxt.sp_wr_hi = rom_word[WRH_BIT];
    ctl_nxt.sp_wr_lo = rom_word[WRL_BIT];
    ctl_nxt.busaddr_mux_sel_buf = rom_word[SBA_BIT];
    ctl_nxt.dmux_onehot = 4'h1 << rom_word[SDM_LSB +: 2];
    ctl_nxt.bmux_select = rom_word[SBM_LSB +: 4];
    ctl_nxt.bconst_select = rom_word[SBC_LSB +: 4];
    if (dad[3:2] == DAD_ALU_IR)
      ctl_nxt.alu_op = ir_alu_op;
    else
      ctl_nxt.alu_op = rom_word[ALU_LSB +: 5];
    ctl_nxt.status_word_control = rom_word[SPS_LSB +: 3];
    ctl_nxt.ps_clk_en = |rom_word[SPS_LSB +: 3];
    ctl_nxt.discrete_alteration_field = dad;
    ctl_nxt.begin_bus_cycle = |bus_code;
    ctl_nxt.odd_chk_en = |bus_code;
    ctl_nxt.stack_chk_en = (|bus_code) && (dad == DAD_STACK_CHK);
    ctl_nxt.bus_xfer_type_hi = bus_code[1];
    ctl_nxt.bus_xfer_type_lo = bus_code[0];
    ctl_nxt.bus_nondata = bus_code[2];
    ctl_nxt.busaddr_reg_clk_en = rom_word[CBA_BIT];
    ctl_nxt.dreg_clk_en = rom_word[CD_BIT];
    ctl_nxt.breg_clk_en = rom_word[CB_BIT];
    ctl_nxt.instr_reg_clk_en = rom_word[CIR_BIT];
    ctl_nxt.branch_group_30s = rom_word[BTEST_LSB + 4] & rom_word[BTEST_LSB + 3];
    ctl_nxt.cycle_length_code = rom_word[CYCLE_LENGTH_CODE_LSB +: 2];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl <= CTL_RESET;
    else if (load_w)
      ctl <= ctl_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped offsets.

  logic setup_w;
  logic hit_w;

  assign setup_w = psel && !penable;
  assign hit_w = (paddr == CTRL_OFS) || (paddr == STAT_OFS) ||
                 (paddr == UWLO_OFS) || (paddr == UWHI_OFS);
  assign soft_start = psel && penable && pready && pwrite && !pslverr &&
                      (paddr == CTRL_OFS) && pwdata[CTRL_START_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup_w;
      pslverr <= setup_w && !hit_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= CTRL_RESET;
    else if (psel && penable && pready && pwrite && (paddr == CTRL_OFS))
      ctrl_r <= {pwdata[CTRL_HALT_BIT], 1'b0};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup_w && !pwrite)
    begin
      unique case (paddr)
        CTRL_OFS: prdata <= {30'h0, ctrl_r};
        STAT_OFS: prdata <= {1'b0, ctl.cycle_length_code, running, 3'h0, upp_r,
                             7'h00, prev_r};
        UWLO_OFS: prdata <= uword_r[31:0];
        UWHI_OFS: prdata <= {5'h00, uword_r[MW_W-1:32]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_imm_addr: assert property (@(posedge pclk) disable iff (!presetn)
    load_w && rom_word[RIMM_BIT] |=> ctl.sp_addr == $past(rom_word[RIF_LSB +: 4]))
    else $error("Immediate scratch pad address not taken.");

  a_ptr_true: assert property (@(posedge pclk) disable iff (!presetn)
    load_w |=> (uword_r[PTR_LSB +: PTR_W] | ~$past(rom_word[PTR_LSB +: PTR_W])) ==
    uword_r[PTR_LSB +: PTR_W])
    else $error("Pointer field not re-inverted.");

  a_alu_ir_sel: assert property (@(posedge pclk) disable iff (!presetn)
    load_w && (rom_word[DAD_LSB + 2 +: 2] == DAD_ALU_IR) |=> ctl.alu_op == $past(ir_alu_op))
    else $error("ALU function not taken from instruction.");

  a_bus_begin: assert property (@(posedge pclk) disable iff (!presetn)
    load_w |=> (ctl.begin_bus_cycle == (|$past(rom_word[BUS_LSB +: 3]))) &&
    (ctl.odd_chk_en == ctl.begin_bus_cycle))
    else $error("Begin bus cycle mismatch.");

  a_long_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    load_w && (rom_word[CYCLE_LENGTH_CODE_LSB +: 2] == 2'b11) && !rom_word[CLOCK_STOP_BIT_BIT] &&
    !ctrl_r[CTRL_HALT_BIT] |=> !load_w [*8] ##22 load_w)
    else $error("Long microcycle is not thirty clocks.");

  a_halt_after: assert property (@(posedge pclk) disable iff (!presetn)
    end_w && stop_pend_r && !start_evt |=> !running ##1 !cycle_strobe)
    else $error("Clock stop did not halt.");

  a_group_30s: assert property (@(posedge pclk) disable iff (!presetn)
    load_w |=> ctl.branch_group_30s == ($past(rom_word[BTEST_LSB + 3 +: 2]) == 2'b11))
    else $error("Group 30 decode wrong.");

  a_no_branch: assert property (@(posedge pclk) disable iff (!presetn)
    load_w && (btest == 5'h00) |=> upp_r == ~$past(rom_word[PTR_LSB +: PTR_W]))
    else $error("Address altered without a branch test.");

  a_prev_addr: assert property (@(posedge pclk) disable iff (!presetn)
    load_w |=> prev_r == $past(upp_r) && cycle_strobe)
    else $error("Previous address not saved.");

  a_start_run: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(start_sync_r) |=> running)
    else $error("Start did not set run.");

endmodule : mwd_decode

// ### rtl/mwd_pkg.sv
// Package with microword field layout, timing constants and shared types.
package mwd_pkg;

  // Microword layout.
  localparam int MW_W = 59;
  localparam int PTR_LSB = 0;
  localparam int PTR_W = 9;
  localparam int RIF_LSB = 9;
  localparam int RIMM_BIT = 13;
  localparam int RSEL_LSB = 14;
  localparam int BTEST_LSB = 17;
  localparam int BTEST_W = 5;
  localparam int SBA_BIT = 22;
  localparam int SDM_LSB = 23;
  localparam int SBM_LSB = 25;
  localparam int SBC_LSB = 29;
  localparam int ALU_LSB = 33;
  localparam int SPS_LSB = 38;
  localparam int DAD_LSB = 41;
  localparam int BUS_LSB = 45;
  localparam int CBA_BIT = 48;
  localparam int CD_BIT = 49;
  localparam int CB_BIT = 50;
  localparam int WRL_BIT = 51;
  localparam int WRH_BIT = 52;
  localparam int CIR_BIT = 55;
  localparam int CYCLE_LENGTH_CODE_LSB = 56;
  localparam int CLOCK_STOP_BIT_BIT = 58;

  // Discrete alteration codes.
  localparam logic [1:0] DAD_ALU_IR = 2'h3;
  localparam logic [3:0] DAD_STACK_CHK = 4'h1;

  // Microcycle timing.
  localparam int CLK_NS = 10;
  localparam int CYC_SHORT_NS = 140;
  localparam int CYC_MED_NS = 200;
  localparam int CYC_LONG_NS = 300;
  localparam logic [4:0] CYC_SHORT = 5'((CYC_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] CYC_MED = 5'((CYC_MED_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] CYC_LONG = 5'((CYC_LONG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] BRANCH_SAMPLE_CNT = 5'h01;

  // Register map.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] UWLO_OFS = 8'h08;
  localparam logic [7:0] UWHI_OFS = 8'h0c;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_HALT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {
    MWD_SP_IMM = 2'b00,
    MWD_SP_BUSADDR = 2'b01,
    MWD_SP_DEST = 2'b10,
    MWD_SP_SRC = 2'b11
  } mwd_spmode_t;

  typedef enum logic {
    MWD_IDLE = 1'b0,
    MWD_RUN = 1'b1
  } mwd_state_t;

  typedef struct packed {
    logic [3:0] sp_addr;
    mwd_spmode_t sp_mode;
    logic sp_wr_hi;
    logic sp_wr_lo;
    logic busaddr_mux_sel_buf;
    logic [3:0] dmux_onehot;
    logic [3:0] bmux_select;
    logic [3:0] bconst_select;
    logic [4:0] alu_op;
    logic [2:0] status_word_control;
    logic ps_clk_en;
    logic [3:0] discrete_alteration_field;
    logic odd_chk_en;
    logic stack_chk_en;
    logic begin_bus_cycle;
    logic bus_xfer_type_hi;
    logic bus_xfer_type_lo;
    logic bus_nondata;
    logic busaddr_reg_clk_en;
    logic dreg_clk_en;
    logic breg_clk_en;
    logic instr_reg_clk_en;
    logic branch_group_30s;
    logic [1:0] cycle_length_code;
  } mwd_ctl_t;

  localparam mwd_ctl_t CTL_RESET = '0;

endpackage : mwd_pkg

// ### rtl/mwd_bmux.sv
// One branch-test multiplexer feeding a single next-address bit.
`timescale 1ns/100ps
module mwd_bmux #(
  parameter int N = 4
) (
  // Selection
  input wire logic [$clog2(N)-1:0] sel,
  input wire logic en,
  // Data
  input wire logic [N-1:0] din,
  output logic dout
);

  assign dout = en & din[sel];

endmodule : mwd_bmux

// ### tb/mwd_rom_model.sv
// Behavioural model of the microprogram ROM that faces the decoder.
`timescale 1ns/100ps
module mwd_rom_model (
  // Address from the sequencer
  input wire logic [mwd_pkg::PTR_W-1:0] rom_addr,
  // Word back to the sequencer
  output logic [mwd_pkg::MW_W-1:0] rom_word
);
  import mwd_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // The bench loads the contents; the pointer field is kept complemented.
  logic [MW_W-1:0] mem [0:511];
  // Answers within the same cycle, so the word is settled long before a load.
  assign rom_word = mem[rom_addr];
endmodule : mwd_rom_model

// ### tb/tb.sv
// Self-checking bench for the microword decoder and branch sequencer.
`timescale 1ns/100ps
module tb;
  import mwd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, running, cycle_strobe;
  logic [8:0] rom_addr;
  logic [58:0] rom_word;
  logic [2:0] ir_src_reg = 3'h0, ir_dst_reg = 3'h0;
  logic [3:0] busaddr_low = 4'h0, bc4_in = 4'h0, bc5_in = 4'h0;
  logic [4:0] ir_alu_op = 5'h00;
  logic [15:0] branch_bit0_low_tests = 16'h0, branch_bit0_high_tests = 16'h0, bc1_in = 16'h0;
  logic [7:0] bc2_in = 8'h00, bc3_in = 8'h00;
  logic [5:1] exp_branch_code = 5'h00;
  logic start_async = 1'b0;
  mwd_ctl_t ctl;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int last_cyc, last_len;
  logic [31:0] seed = 32'h709db7a9;
  logic [58:0] rom [0:511];
  logic [8:0] cur_a, nxt_a;

  mwd_decode mwd_decode_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rom_addr(rom_addr), .rom_word(rom_word), .ir_src_reg(ir_src_reg),
    .ir_dst_reg(ir_dst_reg), .busaddr_low(busaddr_low), .ir_alu_op(ir_alu_op),
    .branch_bit0_low_tests(branch_bit0_low_tests),
    .branch_bit0_high_tests(branch_bit0_high_tests), .bc1_in(bc1_in), .bc2_in(bc2_in),
    .bc3_in(bc3_in), .bc4_in(bc4_in), .bc5_in(bc5_in), .exp_branch_code(exp_branch_code),
    .start_async(start_async), .running(running), .cycle_strobe(cycle_strobe), .ctl(ctl));
  mwd_rom_model mwd_rom_model_i (.rom_addr(rom_addr), .rom_word(rom_word));

  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // A hung handshake would otherwise stall the run forever.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (e !== g)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  ////////////////////////////////////////////////////////////////////////////////
  // Entered just after a rising edge; leaves the request up so a setup may follow.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
  endtask : apb

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : idle

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic ee);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(nm, e, rd);
    chk(nm, ee, er);
  endtask : rchk

  task automatic shuffle();
    logic [31:0] r;
    r = rnd();
    {ir_src_reg, ir_dst_reg, busaddr_low, ir_alu_op, exp_branch_code} <= r[19:0];
    {bc4_in, bc5_in} <= r[27:20];
    {branch_bit0_low_tests, branch_bit0_high_tests} <= rnd();
    {bc1_in, bc2_in, bc3_in} <= rnd();
  endtask : shuffle

  ////////////////////////////////////////////////////////////////////////////////
  function automatic mwd_ctl_t exp_ctl(input logic [58:0] w);
    mwd_ctl_t e;
    e = CTL_RESET;
    e.sp_addr = w[13] ? w[12:9] : w[14] ? busaddr_low : {1'b0, w[15] ? ir_dst_reg : ir_src_reg};
    e.stack_chk_en = (|w[47:45]) && (w[44:41] == DAD_STACK_CHK);
    e.sp_mode = w[13] ? MWD_SP_IMM : w[14] ? MWD_SP_BUSADDR : w[15] ? MWD_SP_DEST : MWD_SP_SRC;
    e.sp_wr_hi = w[52];
    e.sp_wr_lo = w[51];
    e.busaddr_mux_sel_buf = w[22];
    e.dmux_onehot = 4'h1 << w[24:23];
    e.bmux_select = w[28:25];
    e.bconst_select = w[32:29];
    e.alu_op = (w[44:43] == DAD_ALU_IR) ? ir_alu_op : w[37:33];
    e.status_word_control = w[40:38];
    e.discrete_alteration_field = w[44:41];
    e.odd_chk_en = |w[47:45];
    e.begin_bus_cycle = |w[47:45];
    e.bus_xfer_type_hi = w[46];
    e.bus_xfer_type_lo = w[45];
    e.bus_nondata = w[47];
    e.busaddr_reg_clk_en = w[48];
    e.dreg_clk_en = w[49];
    e.breg_clk_en = w[50];
    e.instr_reg_clk_en = w[55];
    e.branch_group_30s = (w[21:20] == 2'b11);
    e.cycle_length_code = w[57:56];
    return e;
  endfunction : exp_ctl

  function automatic logic [8:0] exp_next(input logic [58:0] w);
    logic [4:0] t;
    logic [8:0] a;
    t = w[21:17];
    a = ~w[8:0];
    if (t != 5'h00)
    begin
      a[0] |= t[4] ? branch_bit0_high_tests[t[3:0]] : branch_bit0_low_tests[t[3:0]];
      a[1] |= t[4] & bc1_in[t[3:0]];
      a[3:2] |= (t[4:3] == 2'b11) ? {bc3_in[t[2:0]], bc2_in[t[2:0]]} : 2'b00;
      a[5:4] |= (t[4:2] == 3'b111) ? {bc5_in[t[1:0]], bc4_in[t[1:0]]} : 2'b00;
      a[5:1] |= exp_branch_code;
    end
    return a;
  endfunction : exp_next

  function automatic int cyc_len(input logic [1:0] c);
    return (c == 2'b11) ? int'(CYC_LONG) : (c == 2'b10) ? int'(CYC_MED) : int'(CYC_SHORT);
  endfunction : cyc_len

  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_cycles(input int k);
    logic [58:0] w;
    mwd_ctl_t g;
    int n;
    for (int i = 0; i < k; i++)
    begin
      n = 0;
      do
      begin
        @(negedge pclk);
        n++;
      end
      while (cycle_strobe !== 1'b1 && n < 40);
      chk("cycle_strobe", 1, cycle_strobe);
      w = rom[cur_a];
      if (last_len > 0)
        chk("microcycle length", last_len, cyc - last_cyc);
      last_len = cyc_len(w[57:56]);
      last_cyc = cyc;
      g = ctl;
      // The status clock enable hangs on undocumented decode and is left out.
      g.ps_clk_en = 1'b0;
      chk("ctl", exp_ctl(w), g);
      chk("running", 1, running);
      nxt_a = exp_next(w);
      @(posedge pclk);
      shuffle();
      rchk("stat", STAT_OFS, {1'b0, w[57:56], 1'b1, 3'h0, nxt_a, 7'h0, cur_a}, 0);
      rchk("uwlo", UWLO_OFS, {w[31:9], nxt_a}, 0);
      rchk("uwhi", UWHI_OFS, {5'h00, w[58:32]}, 0);
      idle();
      cur_a = nxt_a;
    end
  endtask : run_cycles

  task automatic quiet(input int n);
    repeat (n)
    begin
      @(negedge pclk);
      chk("strobe while halted", 0, cycle_strobe);
    end
    chk("running while halted", 0, running);
    last_len = 0;
    @(posedge pclk);
  endtask : quiet

  task automatic set_stop(input logic s);
    for (int a = 0; a < 512; a++)
    begin
      rom[a][58] = s;
      mwd_rom_model_i.mem[a] = rom[a];
    end
  endtask : set_stop

  // The far side's start is a short pulse, long enough for the synchroniser.
  task automatic pulse_start();
    start_async <= 1'b1;
    repeat (2) @(posedge pclk);
    start_async <= 1'b0;
  endtask : pulse_start

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] rd;
    logic er;
    for (int a = 0; a < 512; a++)
      rom[a] = 59'({rnd(), rnd()});
    // Word 0 is the dispatch corner: every field but clock stop set, longest cycle.
    rom[0] = {1'b0, {58{1'b1}}};
    set_stop(1'b0);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("ctl after reset", CTL_RESET, ctl);
    chk("rom_addr after reset", 0, rom_addr);
    chk("running after reset", 0, running);
    rchk("unmapped read", 8'h10, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'hffffffff, rd, er);
    chk("unmapped write", 1, er);
    rchk("ctrl", CTRL_OFS, 32'h0, 1'b0);
    rchk("stat after reset", STAT_OFS, 32'h0, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h1, rd, er);
    idle();
    cur_a = 9'h000;
    last_len = 0;
    run_cycles(100);
    @(posedge pclk);
    apb(1'b1, CTRL_OFS, 32'h2, rd, er);
    idle();
    // The halt request is taken with the next word, so that word still runs.
    run_cycles(1);
    quiet(60);
    apb(1'b1, CTRL_OFS, 32'h0, rd, er);
    idle();
    pulse_start();
    run_cycles(10);
    set_stop(1'b1);
    run_cycles(1);
    quiet(60);
    set_stop(1'b0);
    pulse_start();
    run_cycles(10);
    complete_run();
  end
endmodule : tb
